//--- hw/extbc_ctrl.sv
// External bus controller: request handshake, window decode, bus sequencer
module extbc_ctrl
	import extbc_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rstn,
	input  wire logic                busClk,
	input  wire logic                reqValid,
	input  wire logic [ADDR_W-1:0]   reqAddr,
	input  wire logic                reqWrite,
	input  wire logic [DATA_W-1:0]   reqWdata,
	output logic                     reqReady,
	output logic                     respValid,
	output logic [DATA_W-1:0]        respRdata,
	output logic                     respErr,
	input  wire logic                busEnable,
	input  wire logic [4:0]          addrWidth,
	input  wire logic [2:0]          segLines,
	input  wire logic                readyActHigh,
	input  wire logic [NUM_WIN-1:0]  winEnable,
	input  wire logic [ADDR_W-1:0]   winStart [NUM_WIN],
	input  wire logic [4:0]          winSizeLog [NUM_WIN],
	input  wire logic [NUM_AREA-1:0] areaMux,
	input  wire logic [NUM_AREA-1:0] area16,
	input  wire logic [NUM_AREA-1:0] areaCsEn,
	input  wire logic [NUM_AREA-1:0] areaReadyEn,
	input  wire logic [WAIT_W-1:0]   areaWait [NUM_AREA],
	input  wire logic                clkSrcSys,
	input  wire logic                refPinOut,
	input  wire logic                hsPadEn,
	output logic                     refClkOut,
	output logic                     aleOut,
	output logic                     rdN,
	output logic                     wrN,
	output logic [NUM_AREA-1:0]      csN,
	output logic [15:0]              addrLoOut,
	output logic [7:0]               segAddrOut,
	output logic [DATA_W-1:0]        adOut,
	output logic                     adOe,
	input  wire logic [DATA_W-1:0]   adIn,
	input  wire logic                readyIn,
	output logic                     pbSel,
	output logic                     pbWrite,
	output logic [15:0]              pbAddr,
	output logic [DATA_W-1:0]        pbWdata,
	input  wire logic [DATA_W-1:0]   pbRdata,
	input  wire logic                pbReady
);
	logic                reqReady_r, reqTgl_r, respValid_r, respErr_r;
	logic [DATA_W-1:0]   respRdata_r;
	logic                ans1_r, ans2_r, ans3_r, ansEdge, take, isPer;
	logic [NUM_WIN-1:0]  hit;
	logic [2:0]          area;
	logic [ADDR_W-1:0]   awMask, sgMask, cAddr_r;
	logic [DATA_W-1:0]   cWdata_r;
	logic                cWrite_r, cPer_r, cExt_r, cMux_r, c16_r;
	logic                cCsEn_r, cRdyEn_r, cRdyPol_r;
	logic [2:0]          cArea_r;
	logic [WAIT_W-1:0]   cWait_r;
	logic                clkReq_r, rb1_r, rstBusN_r, q1_r, q2_r, q3_r, pend_r;
	logic                co1_r, co2_r, rdy1_r, rdy2_r, rdyOk;
	logic [DATA_W-1:0]   ad1_r, ad2_r;
	logic                phase_r, tick, refClkOut_r;
	extbc_state_t        state_r;
	logic [WAIT_W-1:0]   cnt_r;
	logic                byteHi_r, lead_r, aleOut_r, rdN_r, wrN_r, adOe_r;
	logic [NUM_AREA-1:0] csN_r;
	logic [15:0]         addrLoOut_r;
	logic [7:0]          segAddrOut_r;
	logic [DATA_W-1:0]   adOut_r;
	logic                pbSel_r, pbWrite_r, bErr_r, ansTgl_r;
	logic [15:0]         pbAddr_r;
	logic [DATA_W-1:0]   pbWdata_r, bRdata_r;

	assign take    = reqValid && reqReady_r;
	assign ansEdge = ans2_r ^ ans3_r;

	// Window match, one comparator per window
	for (genvar i = 0; i < NUM_WIN; i++) begin : g_win
		assign hit[i] = winEnable[i] &&
			(((reqAddr ^ winStart[i]) & (ADDR_ONES << winSizeLog[i])) == '0); // R12
	end

	always_comb begin
		if (hit[3]) begin
			area = 3'h4; // R13
		end else if (hit[2]) begin
			area = 3'h3;
		end else if (hit[1]) begin
			area = 3'h2; // R13
		end else if (hit[0]) begin
			area = 3'h1;
		end else begin
			area = AREA_DEF; // R14
		end
	end

	assign isPer  = (reqAddr >= PB_BASE) && (reqAddr <= PB_LAST);
	assign awMask = (addrWidth >= FULL_AW) ? ADDR_ONES : ~(ADDR_ONES << addrWidth); // R2
	assign sgMask = ~(ADDR_ONES << (SEG_BASE + {2'b00, segLines})); // R7

	// Request side handshake; the word below stays frozen while a request is out
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reqReady_r  <= 1'b1;
			reqTgl_r    <= 1'b0;
			respValid_r <= 1'b0;
			respRdata_r <= '0;
			respErr_r   <= 1'b0;
		end else begin
			respValid_r <= ansEdge;
			if (take) begin
				reqReady_r <= 1'b0;
				reqTgl_r   <= ~reqTgl_r;
			end else if (ansEdge) begin
				reqReady_r  <= 1'b1;
				respRdata_r <= bRdata_r;
				respErr_r   <= bErr_r;
			end
		end
	end

	// Per-access capture of the hit area's settings
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cAddr_r   <= '0;
			cWdata_r  <= '0;
			cWrite_r  <= 1'b0;
			cPer_r    <= 1'b0;
			cExt_r    <= 1'b0;
			cArea_r   <= AREA_DEF;
			cMux_r    <= 1'b0;
			c16_r     <= 1'b0;
			cCsEn_r   <= 1'b0;
			cRdyEn_r  <= 1'b0;
			cRdyPol_r <= 1'b0;
			cWait_r   <= '0;
		end else if (take) begin
			cAddr_r   <= isPer ? reqAddr : (reqAddr & awMask & sgMask); // R2 R7
			cWdata_r  <= reqWdata;
			cWrite_r  <= reqWrite;
			cPer_r    <= isPer; // R18
			cExt_r    <= busEnable; // R1
			cArea_r   <= area;
			cMux_r    <= areaMux[area]; // R17
			c16_r     <= area16[area]; // R17
			cCsEn_r   <= areaCsEn[area];
			cRdyEn_r  <= areaReadyEn[area];
			cRdyPol_r <= readyActHigh; // R11
			cWait_r   <= areaWait[area]; // R9
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			clkReq_r <= 1'b0;
			ans1_r   <= 1'b0;
			ans2_r   <= 1'b0;
			ans3_r   <= 1'b0;
		end else begin
			clkReq_r <= clkSrcSys && refPinOut && hsPadEn; // R19
			ans1_r   <= ansTgl_r;
			ans2_r   <= ans1_r;
			ans3_r   <= ans2_r;
		end
	end

	// Bus-side reset released in step with the bus clock
	always_ff @(posedge busClk or negedge rstn) begin
		if (!rstn) begin
			rb1_r     <= 1'b0;
			rstBusN_r <= 1'b0;
		end else begin
			rb1_r     <= 1'b1;
			rstBusN_r <= rb1_r;
		end
	end

	always_ff @(posedge busClk or negedge rstBusN_r) begin
		if (!rstBusN_r) begin
			q1_r   <= 1'b0;
			q2_r   <= 1'b0;
			q3_r   <= 1'b0;
			co1_r  <= 1'b0;
			co2_r  <= 1'b0;
			rdy1_r <= 1'b0;
			rdy2_r <= 1'b0;
			ad1_r  <= '0;
			ad2_r  <= '0;
		end else begin
			q1_r   <= reqTgl_r;
			q2_r   <= q1_r;
			q3_r   <= q2_r;
			co1_r  <= clkReq_r;
			co2_r  <= co1_r;
			rdy1_r <= readyIn;
			rdy2_r <= rdy1_r;
			ad1_r  <= adIn;
			ad2_r  <= ad1_r;
		end
	end

	assign rdyOk = (rdy2_r == cRdyPol_r); // R11

	// Outputs move as the reference clock falls, so they are settled at its rise
	always_ff @(posedge busClk or negedge rstBusN_r) begin
		if (!rstBusN_r) begin
			phase_r     <= 1'b0;
			refClkOut_r <= 1'b0;
		end else begin
			phase_r     <= ~phase_r;
			refClkOut_r <= co2_r && phase_r; // R16 R19
		end
	end

	assign tick = ~phase_r;

	always_ff @(posedge busClk or negedge rstBusN_r) begin
		if (!rstBusN_r) begin
			pend_r <= 1'b0;
		end else if (q2_r ^ q3_r) begin
			pend_r <= 1'b1;
		end else if (tick && state_r == B_IDLE) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge busClk or negedge rstBusN_r) begin
		if (!rstBusN_r) begin
			state_r      <= B_IDLE;
			cnt_r        <= '0;
			byteHi_r     <= 1'b0;
			lead_r       <= 1'b0;
			aleOut_r     <= 1'b0;
			rdN_r        <= 1'b1;
			wrN_r        <= 1'b1;
			csN_r        <= CS_IDLE;
			addrLoOut_r  <= '0;
			segAddrOut_r <= '0;
			adOut_r      <= '0;
			adOe_r       <= 1'b0;
			pbSel_r      <= 1'b0;
			pbWrite_r    <= 1'b0;
			pbAddr_r     <= '0;
			pbWdata_r    <= '0;
			bRdata_r     <= '0;
			bErr_r       <= 1'b0;
			ansTgl_r     <= 1'b0;
		end else if (tick) begin
			case (state_r)
			B_IDLE: begin
				if (pend_r) begin
					byteHi_r <= 1'b0;
					bErr_r   <= 1'b0;
					bRdata_r <= '0;
					if (cPer_r) begin
						pbSel_r   <= 1'b1; // R18
						pbWrite_r <= cWrite_r;
						pbAddr_r  <= cAddr_r[15:0];
						pbWdata_r <= cWdata_r;
						state_r   <= B_CMD;
					end else if (!cExt_r) begin
						bErr_r  <= 1'b1; // R1
						state_r <= B_END;
					end else begin
						aleOut_r     <= 1'b1; // R20
						addrLoOut_r  <= {cAddr_r[15:1], cAddr_r[0] & c16_r}; // R6
						segAddrOut_r <= cAddr_r[23:16]; // R7
						adOut_r      <= {cAddr_r[15:1], cAddr_r[0] & c16_r}; // R5
						adOe_r       <= cMux_r; // R4
						if (cCsEn_r) begin
							csN_r[cArea_r] <= 1'b0; // R8 R15
						end
						state_r <= B_ADDR;
					end
				end
			end
			B_ADDR: begin
				aleOut_r <= 1'b0;
				rdN_r    <= cWrite_r;
				wrN_r    <= ~cWrite_r;
				adOe_r   <= cWrite_r; // R20
				if (c16_r) begin
					adOut_r <= cWdata_r; // R3
				end else begin
					adOut_r <= {8'h00, byteHi_r ? cWdata_r[15:8] : cWdata_r[7:0]}; // R3
				end
				cnt_r   <= cWait_r; // R9
				lead_r  <= 1'b1;
				state_r <= B_CMD;
			end
			B_CMD: begin
				if (cPer_r) begin
					if (pbReady) begin
						pbSel_r <= 1'b0;
						if (!cWrite_r) begin
							bRdata_r <= pbRdata;
						end
						state_r <= B_END;
					end
				end else if (lead_r) begin
					// Pin data lags two flops, so the strobe's first tick never ends it
					lead_r <= 1'b0; // R10
				end else if (cnt_r != '0) begin
					cnt_r <= cnt_r - 4'h1; // R9
				end else if (!cRdyEn_r || rdyOk) begin // R10
					rdN_r <= 1'b1;
					wrN_r <= 1'b1;
					if (!c16_r && !byteHi_r) begin
						// Odd byte goes out as a second full cycle at address + 1
						if (!cWrite_r) begin
							bRdata_r[7:0] <= ad2_r[7:0];
						end
						byteHi_r    <= 1'b1; // R3
						aleOut_r    <= 1'b1;
						addrLoOut_r <= {addrLoOut_r[15:1], 1'b1};
						adOut_r     <= {addrLoOut_r[15:1], 1'b1};
						adOe_r      <= cMux_r;
						state_r     <= B_ADDR;
					end else begin
						if (!cWrite_r && c16_r) begin
							bRdata_r <= ad2_r;
						end else if (!cWrite_r) begin
							bRdata_r[15:8] <= ad2_r[7:0];
						end
						csN_r   <= CS_IDLE;
						adOe_r  <= 1'b0;
						state_r <= B_END;
					end
				end
			end
			B_END: begin
				ansTgl_r <= ~ansTgl_r;
				state_r  <= B_IDLE;
			end
			default: begin
				state_r <= B_IDLE;
			end
			endcase
		end
	end

	assign reqReady   = reqReady_r;
	assign respValid  = respValid_r;
	assign respRdata  = respRdata_r;
	assign respErr    = respErr_r;
	assign refClkOut  = refClkOut_r;
	assign aleOut     = aleOut_r;
	assign rdN        = rdN_r;
	assign wrN        = wrN_r;
	assign csN        = csN_r;
	assign addrLoOut  = addrLoOut_r;
	assign segAddrOut = segAddrOut_r;
	assign adOut      = adOut_r;
	assign adOe       = adOe_r;
	assign pbSel      = pbSel_r;
	assign pbWrite    = pbWrite_r;
	assign pbAddr     = pbAddr_r;
	assign pbWdata    = pbWdata_r;

	default clocking cb @(posedge busClk); endclocking
	default disable iff (!rstBusN_r);

	property p_single;
		state_r == B_IDLE && tick && pend_r && !cPer_r && !cExt_r
			|=> csN_r == CS_IDLE && !aleOut_r ##1 csN_r == CS_IDLE;
	endproperty
	a_single: assert property (p_single) else $error("bus touched in single-chip mode"); // R1

	property p_mask;
		@(posedge clock) disable iff (!rstn)
		take && !isPer |=> (cAddr_r & ~$past(awMask)) == '0;
	endproperty
	a_mask: assert property (p_mask) else $error("address beyond programmed width"); // R2

	property p_byte;
		state_r == B_CMD && !cPer_r && !c16_r && byteHi_r |-> addrLoOut_r[0];
	endproperty
	a_byte: assert property (p_byte) else $error("second byte not at odd address"); // R3

	property p_mux;
		aleOut_r && cMux_r |-> adOe_r && adOut_r == addrLoOut_r;
	endproperty
	a_mux: assert property (p_mux) else $error("mux address phase wrong"); // R20

	property p_wait;
		state_r == B_ADDR && tick && !cPer_r && cWait_r == 4'h2 && !cRdyEn_r
			|=> (state_r == B_CMD)[*8] ##1 state_r != B_CMD;
	endproperty
	a_wait: assert property (p_wait) else $error("wait count not honoured"); // R9

	property p_ready;
		state_r == B_CMD && !cPer_r && cnt_r == '0 && cRdyEn_r && !rdyOk && tick
			|=> state_r == B_CMD && (!rdN_r || !wrN_r);
	endproperty
	a_ready: assert property (p_ready) else $error("access ended without ready"); // R10

	property p_prio;
		@(posedge clock) disable iff (!rstn)
		take && hit[3] |=> cArea_r == 3'h4;
	endproperty
	a_prio: assert property (p_prio) else $error("window 4 lost priority"); // R13

	property p_default;
		@(posedge clock) disable iff (!rstn)
		take && hit == '0 |=> cArea_r == AREA_DEF && cWait_r == $past(areaWait[0]);
	endproperty
	a_default: assert property (p_default) else $error("default area not used"); // R14

	property p_cs;
		state_r == B_CMD && !cPer_r && cCsEn_r |-> !csN_r[cArea_r];
	endproperty
	a_cs: assert property (p_cs) else $error("chip select missing"); // R15

	property p_edge;
		$changed(aleOut_r) || $changed(rdN_r) |-> !refClkOut_r;
	endproperty
	a_edge: assert property (p_edge) else $error("strobe moved at clock rise"); // R16

	property p_clk;
		!co2_r |=> !refClkOut_r;
	endproperty
	a_clk: assert property (p_clk) else $error("reference clock without enable"); // R19

	c_rd16: cover property (state_r == B_CMD && c16_r && !cWrite_r && !rdN_r);
	c_wr8: cover property (state_r == B_CMD && !c16_r && cWrite_r && byteHi_r);
	c_per: cover property (pbSel_r && pbReady);
	c_rdy: cover property (state_r == B_CMD && cRdyEn_r && !rdyOk ##2 rdyOk);
endmodule : extbc_ctrl

//--- hw/extbc_pkg.sv
// Constants and types for the external bus controller
// Functional notes
// R1: Single-chip mode idle, or external bus mode
// R2: Address width programmable from 0 to 24
// R3: Data bus width 8 or 16 bits
// R4: Multiplexed and demultiplexed bus operation
// R5: Address/data on the shared AD lines
// R6: Demux mode: low address on dedicated lines
// R7: Segment line count limits space 64K..8M
// R8: Chip selects for windows and default area
// R9: Timing programmable per chip-select area
// R10: Access waits until ready is active
// R11: Ready active level set by software
// R12: Four independent address windows
// R13: Window 4 over 3, window 2 over 1
// R14: Unmatched addresses use default area settings
// R15: Hit window asserts its chip select
// R16: Bus timing referenced to reference clock rise
// R17: Width and mux mode switch per access
// R18: On-chip peripheral bus served like external
// R19: Reference clock needs source, pin, pad enabled
// R20: Mux mode: address with latch strobe, then data
package extbc_pkg;
	localparam int          ADDR_W    = 24;
	localparam int          DATA_W    = 16;
	localparam int          NUM_WIN   = 4;
	localparam int          NUM_AREA  = 5;
	localparam int          WAIT_W    = 4;
	localparam logic [23:0] ADDR_ONES = 24'hFFFFFF;
	localparam logic [23:0] PB_BASE   = 24'h200000;
	localparam logic [23:0] PB_LAST   = 24'h20BFFF;
	localparam logic [4:0]  FULL_AW   = 5'h18;
	localparam logic [4:0]  SEG_BASE  = 5'h10;
	localparam logic [4:0]  CS_IDLE   = 5'h1F;
	localparam logic [2:0]  AREA_DEF  = 3'h0;

	typedef enum logic [2:0] {
		B_IDLE = 3'b000,
		B_ADDR = 3'b001,
		B_CMD  = 3'b010,
		B_END  = 3'b011
	} extbc_state_t;
endpackage : extbc_pkg

//--- tb/extbc_bus_model.sv
// Partner model: external byte memory and on-chip peripheral responder
module extbc_bus_model
	import extbc_pkg::*;
(
	input  wire logic                busClk,
	input  wire logic                refClkOut,
	input  wire logic                aleOut,
	input  wire logic                rdN,
	input  wire logic                wrN,
	input  wire logic [NUM_AREA-1:0] csN,
	input  wire logic [15:0]         addrLoOut,
	input  wire logic [7:0]          segAddrOut,
	input  wire logic [DATA_W-1:0]   adOut,
	output logic      [DATA_W-1:0]   adIn,
	output logic                     readyIn,
	input  wire logic                muxMode,
	input  wire logic                bus16,
	input  wire logic                readyHigh,
	input  wire logic [3:0]          readyDelay,
	input  wire logic [3:0]          pbDelay,
	input  wire logic                pbSel,
	input  wire logic                pbWrite,
	input  wire logic [15:0]         pbAddr,
	input  wire logic [DATA_W-1:0]   pbWdata,
	output logic      [DATA_W-1:0]   pbRdata,
	output logic                     pbReady,
	output int                       aleCount,
	output int                       strobeLen,
	output logic      [23:0]         lastAddr,
	output logic      [NUM_AREA-1:0] lastCs,
	output logic      [15:0]         pbLastAddr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  mem [logic [23:0]];
	logic [15:0] pmem [logic [15:0]];
	logic [15:0] rdWord;
	logic [15:0] junk = 16'hA55A;
	int          lowCnt = 0;
	int          pbCnt = 0;
	function automatic logic [7:0] rb(input logic [23:0] a);
		return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
	endfunction : rb
	initial begin
		aleCount = 0;
		strobeLen = 0;
		pbReady = 1'b0;
		pbRdata = 16'h0F0F;
	end
	// Sampling on the reference clock rise, where bus outputs sit mid-period
	always @(posedge refClkOut) begin
		if (aleOut) begin
			lastAddr = {segAddrOut, muxMode ? adOut : addrLoOut};
			lastCs = csN;
			aleCount++;
			rdWord = bus16 ? {rb(lastAddr | 24'h000001), rb(lastAddr)} : {junk[15:8], rb(lastAddr)};
		end
		if (!wrN) begin
			mem[lastAddr] = adOut[7:0];
			if (bus16) mem[lastAddr | 24'h000001] = adOut[15:8];
		end
	end
	// Released lines keep changing so a late sample cannot pass by luck
	always @(posedge busClk) junk <= ~junk;
	assign adIn = !rdN ? rdWord : junk;
	always @(posedge busClk) begin
		if (!rdN || !wrN) begin
			lowCnt <= lowCnt + 1;
		end else begin
			if (lowCnt != 0) strobeLen <= lowCnt;
			lowCnt <= 0;
		end
	end
	assign readyIn = ((!rdN || !wrN) && lowCnt >= readyDelay) ? readyHigh : !readyHigh;
	always @(posedge busClk) begin
		if (!pbSel) begin
			pbCnt <= 0;
			pbReady <= 1'b0;
			pbRdata <= ~pbRdata;
		end else begin
			pbCnt <= pbCnt + 1;
			pbLastAddr <= pbAddr;
			if (pbCnt >= pbDelay) begin
				pbReady <= 1'b1;
				pbRdata <= pmem.exists(pbAddr) ? pmem[pbAddr] : ~pbAddr;
				if (pbWrite) pmem[pbAddr] = pbWdata;
			end else begin
				pbRdata <= ~pbRdata;
			end
		end
	end
endmodule : extbc_bus_model

//--- tb/extbc_ctrl_tb.sv
// Self-checking testbench for the external bus controller
module extbc_ctrl_tb
	import extbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0, busClk = 1'b0, rstn = 1'b0;
	logic reqValid = 1'b0, reqWrite = 1'b0, busEnable = 1'b1, readyActHigh = 1'b1;
	logic [23:0] reqAddr = 24'h000000;
	logic [15:0] reqWdata = 16'h0000;
	logic [4:0] addrWidth = 5'h18;
	logic [2:0] segLines = 3'h7;
	logic [3:0] winEnable = 4'hF, readyDelay = 4'h0, pbDelay = 4'h0;
	logic [23:0] winStart [NUM_WIN];
	logic [4:0] winSizeLog [NUM_WIN];
	logic [4:0] areaMux = 5'h00, area16 = 5'h1F, areaCsEn = 5'h1F, areaReadyEn = 5'h00;
	logic [3:0] areaWait [NUM_AREA];
	logic clkSrcSys = 1'b1, refPinOut = 1'b1, hsPadEn = 1'b1, muxMode = 1'b0, bus16 = 1'b1;
	logic reqReady, respValid, respErr, refClkOut, aleOut, rdN, wrN, adOe;
	logic pbSel, pbWrite, pbReady, readyIn;
	logic [15:0] respRdata, addrLoOut, adOut, adIn, pbAddr, pbWdata, pbRdata, pbLastAddr;
	logic [7:0] segAddrOut;
	logic [4:0] csN, lastCs;
	logic [23:0] lastAddr;
	logic [7:0] shadow [logic [23:0]];
	int aleCount, strobeLen, num_errors = 0, total_checks = 0, cyc = 0, refRises = 0;
	initial forever #12.5 clock = ~clock;
	initial begin
		#1.7;
		forever #3 busClk = ~busClk;
	end
	always @(posedge refClkOut) refRises++;
	extbc_ctrl i_dut (.clock(clock), .rstn(rstn), .busClk(busClk), .reqValid(reqValid),
		.reqAddr(reqAddr), .reqWrite(reqWrite), .reqWdata(reqWdata), .reqReady(reqReady),
		.respValid(respValid), .respRdata(respRdata), .respErr(respErr), .busEnable(busEnable),
		.addrWidth(addrWidth), .segLines(segLines), .readyActHigh(readyActHigh),
		.winEnable(winEnable), .winStart(winStart), .winSizeLog(winSizeLog), .areaMux(areaMux),
		.area16(area16), .areaCsEn(areaCsEn), .areaReadyEn(areaReadyEn), .areaWait(areaWait),
		.clkSrcSys(clkSrcSys), .refPinOut(refPinOut), .hsPadEn(hsPadEn), .refClkOut(refClkOut),
		.aleOut(aleOut), .rdN(rdN), .wrN(wrN), .csN(csN), .addrLoOut(addrLoOut),
		.segAddrOut(segAddrOut), .adOut(adOut), .adOe(adOe), .adIn(adIn), .readyIn(readyIn),
		.pbSel(pbSel), .pbWrite(pbWrite), .pbAddr(pbAddr), .pbWdata(pbWdata), .pbRdata(pbRdata),
		.pbReady(pbReady));
	extbc_bus_model i_mem (.busClk(busClk), .refClkOut(refClkOut), .aleOut(aleOut), .rdN(rdN),
		.wrN(wrN), .csN(csN), .addrLoOut(addrLoOut), .segAddrOut(segAddrOut), .adOut(adOut),
		.adIn(adIn), .readyIn(readyIn), .muxMode(muxMode), .bus16(bus16),
		.readyHigh(readyActHigh), .readyDelay(readyDelay), .pbDelay(pbDelay), .pbSel(pbSel),
		.pbWrite(pbWrite), .pbAddr(pbAddr), .pbWdata(pbWdata), .pbRdata(pbRdata),
		.pbReady(pbReady), .aleCount(aleCount), .strobeLen(strobeLen), .lastAddr(lastAddr),
		.lastCs(lastCs), .pbLastAddr(pbLastAddr));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	function automatic logic [7:0] sb(input logic [23:0] a);
		return shadow.exists(a) ? shadow[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
	endfunction : sb
	function automatic logic [15:0] expWord(input logic [23:0] a);
		return {sb(a | 24'h000001), sb(a & 24'hFFFFFE)};
	endfunction : expWord
	// Highest-numbered enabled window that covers the address wins
	function automatic logic [2:0] expArea(input logic [23:0] a);
		for (int k = NUM_WIN - 1; k >= 0; k--) begin
			if (winEnable[k] && ((a ^ winStart[k]) >> winSizeLog[k]) == 0) return 3'(k + 1);
		end
		return AREA_DEF;
	endfunction : expArea
	task automatic access(input logic [23:0] a, input logic w, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		int n;
		n = 0;
		@(negedge clock);
		reqAddr = a;
		reqWrite = w;
		reqWdata = d;
		reqValid = 1'b1;
		while (reqReady !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		@(posedge clock);
		@(negedge clock);
		reqValid = 1'b0;
		while (respValid !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		q = respRdata;
		e = respErr;
		chk(n < 400, "no answer");
	endtask : access
	task automatic bus_access(input logic [23:0] a, input logic w);
		logic [15:0] d, q;
		logic e;
		logic [2:0] ar;
		int ac;
		ar = expArea(a);
		muxMode = areaMux[ar];
		bus16 = area16[ar];
		d = 16'($urandom);
		ac = aleCount;
		access(a, w, d, q, e);
		chk(aleCount - ac == (area16[ar] ? 1 : 2), "address cycles");
		chk(lastCs === (areaCsEn[ar] ? ~(5'h01 << ar) : CS_IDLE), "chip select");
		chk(strobeLen >= 2 * (areaWait[ar] + 1), "strobe too short");
		if (areaReadyEn[ar]) chk(strobeLen >= readyDelay + 2, "ready ignored");
		if (w) begin
			shadow[a] = d[7:0];
			shadow[a | 24'h000001] = d[15:8];
		end else begin
			chk(q === expWord(a), "read data");
		end
	endtask : bus_access
	initial begin
		logic [15:0] q, d;
		logic e;
		logic [23:0] a;
		int r;
		winStart = '{24'h010000, 24'h018000, 24'h100000, 24'h120000};
		winSizeLog = '{5'h10, 5'h0C, 5'h12, 5'h0E};
		areaWait = '{4'h0, 4'h1, 4'h0, 4'h2, 4'h3};
		void'($urandom(76773));
		repeat (16) @(posedge clock);
		chk(reqReady === 1'b1 && csN === CS_IDLE && rdN === 1'b1 && wrN === 1'b1, "reset");
		chk(aleOut === 1'b0 && pbSel === 1'b0 && respValid === 1'b0, "reset idle");
		@(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		busEnable = 1'b0;
		r = aleCount;
		access(24'h040000, 1'b0, 16'h0000, q, e);
		chk(e === 1'b1 && aleCount == r, "single chip refusal");
		busEnable = 1'b1;
		access(24'h040000, 1'b0, 16'h0000, q, e);
		chk(e === 1'b0 && q === expWord(24'h040000), "external read");
		$display("test single_chip done");
		for (int rnd = 0; rnd < 10; rnd++) begin
			@(negedge clock);
			{areaMux, area16, areaCsEn, areaReadyEn} = 20'($urandom);
			{winEnable, readyDelay, readyActHigh} = 9'($urandom);
			if (rnd == 0) winEnable = 4'hF;
			for (int k = 0; k < NUM_AREA; k++) areaWait[k] = 4'($urandom_range(3));
			repeat (4) @(negedge clock);
			for (int i = 0; i < 10; i++) begin
				a = 24'h010000;
				case ($urandom_range(4))
					0: a = 24'h018000;
					1: a = 24'h100000;
					2: a = 24'h120000;
					3: a = 24'h040000;
					default: a = 24'h010000;
				endcase
				a = a + 24'($urandom_range(16'h07FF) * 2);
				bus_access(a, 1'b1);
				bus_access(a, 1'($urandom));
			end
		end
		$display("test windows done");
		areaMux = 5'h00;
		area16 = 5'h1F;
		muxMode = 1'b0;
		bus16 = 1'b1;
		addrWidth = 5'h0C;
		access(24'h013456, 1'b0, 16'h0000, q, e);
		chk(lastAddr === 24'h000456 && q === expWord(24'h000456), "address width");
		addrWidth = 5'h18;
		segLines = 3'h0;
		access(24'h123456, 1'b0, 16'h0000, q, e);
		chk(lastAddr === 24'h003456 && q === expWord(24'h003456), "segment lines");
		segLines = 3'h7;
		$display("test address lines done");
		for (int i = 0; i < 6; i++) begin
			pbDelay = 4'($urandom_range(5));
			a = PB_BASE + 24'($urandom_range(16'h5FFF) * 2);
			d = 16'($urandom);
			access(a, 1'b1, d, q, e);
			access(a, 1'b0, 16'h0000, q, e);
			chk(q === d && pbLastAddr === a[15:0], "peripheral access");
		end
		$display("test peripheral done");
		for (int k = 0; k < 3; k++) begin
			@(negedge clock);
			{clkSrcSys, refPinOut, hsPadEn} = ~(3'b001 << k);
			repeat (4) @(negedge clock);
			r = refRises;
			repeat (10) @(negedge clock);
			chk(refRises == r && refClkOut === 1'b0, "reference clock gated");
		end
		{clkSrcSys, refPinOut, hsPadEn} = 3'b111;
		r = refRises;
		repeat (10) @(negedge clock);
		chk(refRises > r, "reference clock running");
		$display("test reference clock done");
		complete_run();
	end
endmodule : extbc_ctrl_tb
